//--- design/rsc_top.sv
// Register bank for reference selection and input modes of the main DPLL
`timescale 1ns/1ps
`default_nettype none
module rsc_top
   import rsc_pkg::*;
#(
   parameter logic [32:0] PH_TIMEOUT_CYC = PH_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Source monitoring
   input wire logic [NUM_CHAN-1:0] chan_valid_i,
   input wire logic [4*NUM_CHAN-1:0] chan_prio_i,
   input wire logic dpll_locked_i,
   input wire logic [3:0] sync_source_i,
   input wire logic [NUM_CHAN-1:0] phase_alarm_i,
   // Straps and auxiliary path
   input wire logic network_type_pin_i,
   input wire logic aux_output_source_i,
   input wire logic aux_main_rate_i,
   // Selection results
   output logic [3:0] selected_channel_o,
   output logic [2:0] dpll_state_o,
   // Mode controls
   output logic extsync_enable_o,
   output logic osc_edge_select_o,
   output logic man_holdover_o,
   output logic ethernet_pll_reset_o,
   output logic network_type_select_o,
   output logic aux_sonet_rate_o,
   output logic [NUM_CHAN-1:0] phase_alarm_o,
   // Interrupt
   output logic irq_o
);
   // ==============================================
   // Byte lane mask from Wishbone select
   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // Masked merge of written data into a register value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] s);
      merge = (old & ~lane_mask(s)) | (dat & lane_mask(s));
   endfunction

   // ==============================================
   // Storage
   logic [7:0] mode;
   logic [3:0] forced;
   logic strap_done;
   logic [NUM_CHAN-1:0] ph_alarm;
   logic [32:0] ph_count [NUM_CHAN];
   logic [NUM_CHAN-1:0] ph_expire;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_en;
   logic [3:0] prev_sel;
   rsc_state_t prev_state;

   // Bus decode
   logic bus_req;
   logic wr_now;
   logic [31:0] rd_val;
   logic [31:0] wr_mode;
   logic [31:0] wr_forced;
   logic [31:0] wr_ph;
   logic [31:0] wr_clr;
   logic [31:0] wr_en;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_clear;
   logic [NUM_CHAN-1:0] ph_sw_clear;

   rsc_sel_if sel_bus ();

   // ==============================================
   // Selection engine
   rsc_ref_select u_select (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel(sel_bus.sel),
      .chan_valid_i(chan_valid_i),
      .chan_prio_i(chan_prio_i),
      .dpll_locked_i(dpll_locked_i)
   );

   assign sel_bus.forced = forced;
   assign sel_bus.revertive = mode[MODE_REVERTIVE];

   // ==============================================
   // Wishbone handshake
   assign bus_req = wb_cyc_i && wb_stb_i;
   // Writes land on the edge where the master samples ack
   assign wr_now = bus_req && wb_we_i && wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      case (wb_adr_i)
         OFS_FORCED: begin
            rd_val = {28'h0000000, forced};
         end
         OFS_MODE: begin
            rd_val = {24'h000000, mode & MODE_RW_MASK};
         end
         OFS_SELSTAT: begin
            rd_val = {25'h0000000, sel_bus.state, sel_bus.selected};
         end
         OFS_PHALARM: begin
            rd_val = {17'h00000, ph_alarm};
         end
         OFS_IRQ_STAT: begin
            rd_val = {29'h00000000, irq_stat};
         end
         OFS_IRQ_EN: begin
            rd_val = {29'h00000000, irq_en};
         end
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (bus_req && !wb_ack_o && !wb_we_i) begin
         wb_dat_o <= rd_val;
      end
   end

   // Merged write values; alarm and interrupt clear strobes are only lane-masked
   assign wr_mode = merge({24'h000000, mode}, wb_dat_i, wb_sel_i);
   assign wr_forced = merge({28'h0000000, forced}, wb_dat_i, wb_sel_i);
   assign wr_ph = wb_dat_i & lane_mask(wb_sel_i);
   assign wr_clr = wb_dat_i & lane_mask(wb_sel_i);
   assign wr_en = merge({29'h00000000, irq_en}, wb_dat_i, wb_sel_i);

   // ==============================================
   // Forced reference register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         forced <= FORCED_RESET;
      end else if (wr_now && wb_adr_i == OFS_FORCED) begin
         forced <= wr_forced[3:0];
      end
   end

   // ==============================================
   // Input mode register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= MODE_RESET;
         strap_done <= 1'b0;
      end else begin
         if (!strap_done) begin
            strap_done <= 1'b1;
            mode[MODE_NET_TYPE] <= network_type_pin_i;
         end
         if (wr_now && wb_adr_i == OFS_MODE) begin
            mode <= wr_mode[7:0] & MODE_RW_MASK;
         end
      end
   end

   // ==============================================
   // Phase alarms with optional automatic time-out
   assign ph_sw_clear = (wr_now && wb_adr_i == OFS_PHALARM) ?
                        wr_ph[NUM_CHAN-1:0] : '0;

   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         ph_expire[i] = mode[MODE_PHALARM_TO] && ph_alarm[i] &&
                        ph_count[i] >= PH_TIMEOUT_CYC - 33'd1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_alarm <= '0;
      end else begin
         // A new alarm wins over a clear in the same cycle
         ph_alarm <= phase_alarm_i |
                     (ph_alarm & ~ph_sw_clear & ~ph_expire);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            ph_count[i] <= 33'd0;
         end
      end else begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (phase_alarm_i[i] || !ph_alarm[i] ||
                !mode[MODE_PHALARM_TO]) begin
               ph_count[i] <= 33'd0;
            end else begin
               ph_count[i] <= ph_count[i] + 33'd1;
            end
         end
      end
   end

   // ==============================================
   // Interrupt status, clear and enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_sel <= CHAN_NONE;
         prev_state <= ST_FREE;
      end else begin
         prev_sel <= sel_bus.selected;
         prev_state <= sel_bus.state;
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[IRQ_SRC_CHANGE] = sel_bus.selected != prev_sel;
      irq_event[IRQ_HOLDOVER] = sel_bus.state == ST_HOLDOVER &&
                                prev_state != ST_HOLDOVER;
      irq_event[IRQ_PH_TIMEOUT] = |ph_expire;
   end

   assign irq_clear = (wr_now && wb_adr_i == OFS_IRQ_CLR) ?
                      wr_clr[IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= '0;
      end else begin
         // Set wins over clear
         irq_stat <= irq_event | (irq_stat & ~irq_clear);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en <= '0;
      end else if (wr_now && wb_adr_i == OFS_IRQ_EN) begin
         irq_en <= wr_en[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_en);
      end
   end

   // ==============================================
   // Selection results
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         selected_channel_o <= CHAN_NONE;
         dpll_state_o <= ST_FREE;
      end else begin
         selected_channel_o <= sel_bus.selected;
         dpll_state_o <= sel_bus.state;
      end
   end

   // ==============================================
   // Mode control outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         extsync_enable_o <= 1'b0;
      end else begin
         extsync_enable_o <= mode[MODE_EXTSYNC_AUTO] &&
                             mode[MODE_ETH_PLL_RESET] &&
                             sel_bus.state == ST_LOCKED &&
                             sel_bus.selected == sync_source_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_edge_select_o <= 1'b0;
         man_holdover_o <= 1'b0;
         ethernet_pll_reset_o <= 1'b0;
      end else begin
         osc_edge_select_o <= mode[MODE_OSC_EDGE];
         man_holdover_o <= mode[MODE_MAN_HOLD];
         ethernet_pll_reset_o <= mode[MODE_ETH_PLL_RESET];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         network_type_select_o <= 1'b0;
         aux_sonet_rate_o <= 1'b0;
      end else begin
         network_type_select_o <= mode[MODE_NET_TYPE];
         if (aux_output_source_i) begin
            aux_sonet_rate_o <= aux_main_rate_i;
         end else begin
            aux_sonet_rate_o <= mode[MODE_NET_TYPE];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_alarm_o <= '0;
      end else begin
         phase_alarm_o <= ph_alarm;
      end
   end
endmodule // rsc_top
`default_nettype wire

//--- design/rsc_pkg.sv
// Package: register map, field layout, reset values and timing counts
package rsc_pkg;
   // ==============================================
   // Register byte offsets
   localparam logic [7:0] OFS_FORCED = 8'h30;
   localparam logic [7:0] OFS_MODE = 8'h34;
   localparam logic [7:0] OFS_SELSTAT = 8'h38;
   localparam logic [7:0] OFS_PHALARM = 8'h3C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h44;
   localparam logic [7:0] OFS_IRQ_EN = 8'h48;

   // ==============================================
   // Input mode field positions
   localparam int MODE_EXTSYNC_AUTO = 7;
   localparam int MODE_PHALARM_TO = 6;
   localparam int MODE_OSC_EDGE = 5;
   localparam int MODE_MAN_HOLD = 4;
   localparam int MODE_ETH_PLL_RESET = 3;
   localparam int MODE_NET_TYPE = 2;
   localparam int MODE_REVERTIVE = 0;
   // Reset value; the network type bit is replaced by the strap pin
   localparam logic [7:0] MODE_RESET = 8'hC0;
   localparam logic [7:0] MODE_RW_MASK = 8'hFD;
   localparam logic [3:0] FORCED_RESET = 4'h0;
   localparam logic [3:0] FORCED_AUTO = 4'h0;

   // ==============================================
   // Channels and priorities
   localparam int NUM_CHAN = 15;
   localparam logic [3:0] PRIO_HIGHEST = 4'h1;
   localparam logic [3:0] PRIO_OFF = 4'h0;
   localparam logic [3:0] CHAN_NONE = 4'h0;

   // ==============================================
   // Interrupt bits
   localparam int IRQ_W = 3;
   localparam int IRQ_SRC_CHANGE = 0;
   localparam int IRQ_HOLDOVER = 1;
   localparam int IRQ_PH_TIMEOUT = 2;

   // ==============================================
   // Timing
   localparam longint unsigned CLK_HZ = 40000000;
   localparam longint unsigned PH_TIMEOUT_S = 128;
   localparam logic [32:0] PH_TIMEOUT_CYCLES = 33'(PH_TIMEOUT_S * CLK_HZ);

   // ==============================================
   // Reference selection states
   typedef enum logic [2:0] {
      ST_FREE = 3'b001,
      ST_LOCKED = 3'b010,
      ST_HOLDOVER = 3'b100
   } rsc_state_t;
endpackage

//--- design/rsc_sel_if.sv
// Interface between register bank and reference selection engine
`timescale 1ns/1ps
`default_nettype none
interface rsc_sel_if;
   import rsc_pkg::*;
   logic [3:0] forced;
   logic revertive;
   logic [3:0] selected;
   rsc_state_t state;

   modport ctrl (
      output forced,
      output revertive,
      input selected,
      input state
   );
   modport sel (
      input forced,
      input revertive,
      output selected,
      output state
   );
endinterface
`default_nettype wire

//--- design/rsc_ref_select.sv
// Reference selection engine for the main DPLL
`timescale 1ns/1ps
`default_nettype none
module rsc_ref_select
   import rsc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control and result
   rsc_sel_if.sel sel,
   // Source monitoring
   input wire logic [NUM_CHAN-1:0] chan_valid_i,
   input wire logic [4*NUM_CHAN-1:0] chan_prio_i,
   input wire logic dpll_locked_i
);
   logic [3:0] prio [NUM_CHAN];
   logic [NUM_CHAN-1:0] eff_valid;
   logic [3:0] best;
   logic [3:0] best_prio;
   logic cur_ok;

   // ==============================================
   // Effective priority and validity
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (sel.forced == 4'(i + 1)) begin
            prio[i] = PRIO_HIGHEST;
            eff_valid[i] = 1'b1;
         end else begin
            prio[i] = chan_prio_i[4*i +: 4];
            eff_valid[i] = chan_valid_i[i];
         end
      end
   end

   // Lowest nonzero priority wins; ties go to the lower channel
   always_comb begin
      best = CHAN_NONE;
      best_prio = PRIO_OFF;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (eff_valid[i] && prio[i] != PRIO_OFF &&
             (best == CHAN_NONE || prio[i] < best_prio)) begin
            best = 4'(i + 1);
            best_prio = prio[i];
         end
      end
   end

   always_comb begin
      cur_ok = 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (sel.selected == 4'(i + 1)) begin
            cur_ok = eff_valid[i] && prio[i] != PRIO_OFF;
         end
      end
   end

   // ==============================================
   // Selected source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel.selected <= CHAN_NONE;
      end else if (sel.revertive || !cur_ok) begin
         sel.selected <= best;
      end
   end

   // ==============================================
   // Lock state; a forced source stays valid so no holdover
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel.state <= ST_FREE;
      end else begin
         case (sel.state)
            ST_FREE: begin
               if (cur_ok && dpll_locked_i) begin
                  sel.state <= ST_LOCKED;
               end
            end
            ST_LOCKED: begin
               if (!cur_ok && best == CHAN_NONE) begin
                  sel.state <= ST_HOLDOVER;
               end else if (!dpll_locked_i) begin
                  sel.state <= ST_FREE;
               end
            end
            ST_HOLDOVER: begin
               if (best != CHAN_NONE) begin
                  sel.state <= ST_FREE;
               end
            end
            default: begin
               sel.state <= ST_FREE;
            end
         endcase
      end
   end
endmodule // rsc_ref_select
`default_nettype wire

//--- verif/rsc_top_chk.sv
// Checker for bus timing, mode outputs and forced selection
`timescale 1ns/1ps
`default_nettype none
module rsc_top_chk
   import rsc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Results
   input wire logic [3:0] selected_channel_o,
   input wire logic [2:0] dpll_state_o,
   input wire logic osc_edge_select_o,
   input wire logic man_holdover_o,
   input wire logic ethernet_pll_reset_o,
   input wire logic network_type_select_o,
   input wire logic irq_o
);
   // ==============================================
   // Shadow of forced code, mode bits and settling count
   logic wr_acc;
   logic [3:0] forced_q;
   logic [7:3] mode_q;
   logic rev_q;
   logic [2:0] settle;
   assign wr_acc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         forced_q <= FORCED_RESET;
         mode_q <= MODE_RESET[7:3];
         rev_q <= 1'b0;
         settle <= 3'h0;
      end else begin
         forced_q <= (wr_acc && wb_adr_i == OFS_FORCED) ? wb_dat_i[3:0] : forced_q;
         mode_q <= (wr_acc && wb_adr_i == OFS_MODE) ? wb_dat_i[7:3] : mode_q;
         rev_q <= (wr_acc && wb_adr_i == OFS_MODE) ? wb_dat_i[0] : rev_q;
         settle <= wr_acc ? 3'h0 : (settle == 3'h7 ? settle : settle + 3'h1);
      end
   end

   // ==============================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property follow(b, o);
      wr_acc && wb_adr_i == OFS_MODE |-> ##2 o == $past(wb_dat_i[b], 2);
   endproperty
   ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not given one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   forced_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_FORCED |-> wb_dat_o == {28'h0, forced_q})
      else $error("forced code read back wrong");
   mode_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_MODE |-> wb_dat_o[7:3] == mode_q && !wb_dat_o[1])
      else $error("mode read back wrong");
   edge_sel_a: assert property (follow(MODE_OSC_EDGE, osc_edge_select_o))
      else $error("oscillator edge output wrong");
   hold_sel_a: assert property (follow(MODE_MAN_HOLD, man_holdover_o))
      else $error("manual holdover output wrong");
   eth_rst_a: assert property (follow(MODE_ETH_PLL_RESET, ethernet_pll_reset_o))
      else $error("ethernet pll reset output wrong");
   net_type_a: assert property (follow(MODE_NET_TYPE, network_type_select_o))
      else $error("network type output wrong");
   forced_hold_a: assert property (forced_q != 4'h0 && settle >= 3'h4 |-> dpll_state_o != ST_HOLDOVER)
      else $error("holdover while a channel is forced");
   forced_sel_a: assert property (forced_q != 4'h0 && rev_q && settle >= 3'h4 |-> selected_channel_o == forced_q)
      else $error("forced channel not selected");
   cover property (wr_acc && wb_adr_i == OFS_FORCED);
   cover property (dpll_state_o == ST_HOLDOVER);
   cover property (irq_o);
endmodule // rsc_top_chk

bind rsc_top rsc_top_chk rsc_top_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .selected_channel_o, .dpll_state_o, .osc_edge_select_o, .man_holdover_o,
   .ethernet_pll_reset_o, .network_type_select_o, .irq_o);
`default_nettype wire

//--- verif/rsc_top_tb.sv
// Testbench for the reference select and input mode register bank
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb
   import rsc_pkg::*;
;
   localparam logic [32:0] TO_CYC = 33'h14;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, sync_source_i, selected_channel_o;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [14:0] chan_valid_i, phase_alarm_i, phase_alarm_o;
   logic [59:0] chan_prio_i;
   logic dpll_locked_i, network_type_pin_i, aux_output_source_i, aux_main_rate_i;
   logic [2:0] dpll_state_o;
   logic extsync_enable_o, osc_edge_select_o, man_holdover_o, irq_o;
   logic ethernet_pll_reset_o, network_type_select_o, aux_sonet_rate_o;
   int fails = 0;
   int num_checks = 0;

   always #12.5 clk_i = ~clk_i;

   rsc_top #(.PH_TIMEOUT_CYC(TO_CYC)) rsc_top_i (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .chan_valid_i, .chan_prio_i, .dpll_locked_i, .sync_source_i,
      .phase_alarm_i, .network_type_pin_i, .aux_output_source_i,
      .aux_main_rate_i, .selected_channel_o, .dpll_state_o, .extsync_enable_o,
      .osc_edge_select_o, .man_holdover_o, .ethernet_pll_reset_o,
      .network_type_select_o, .aux_sonet_rate_o, .phase_alarm_o, .irq_o);

   // ==============================================
   // Shared tasks
   task automatic give_verdict;
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fails++;
         give_verdict();
      end
   endtask

   // ==============================================
   // Scenarios
   task automatic reset_values;
      bus(1'b0, OFS_FORCED, 32'h0);
      chk(rd, 32'h0, "forced reset");
      bus(1'b0, OFS_MODE, 32'h0);
      chk(rd, {24'h0, MODE_RESET | 8'h04}, "mode reset with strap");
      chk(32'({osc_edge_select_o, man_holdover_o, ethernet_pll_reset_o}), 32'h0, "mode outputs");
      bus(1'b1, 8'h10, 32'hFF);
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0, "unmapped read");
   endtask

   task automatic mode_bits;
      logic [7:0] v [3];
      v = '{8'h3D, 8'hFF, 8'h00};
      foreach (v[i]) begin
         bus(1'b1, OFS_MODE, {24'h0, v[i]});
         tick(2);
         chk(32'({osc_edge_select_o, man_holdover_o, ethernet_pll_reset_o,
            network_type_select_o}), 32'(v[i][5:2]), "mode outputs");
         chk(32'(aux_sonet_rate_o), 32'(v[i][2]), "aux rate");
         bus(1'b0, OFS_MODE, 32'h0);
         chk(rd, {24'h0, v[i] & MODE_RW_MASK}, "mode readback");
      end
      aux_output_source_i <= 1'b1;
      aux_main_rate_i <= 1'b1;
      tick(3);
      chk(32'(aux_sonet_rate_o), 32'h1, "aux rate from main");
      aux_output_source_i <= 1'b0;
   endtask

   task automatic forced_codes;
      bus(1'b1, OFS_FORCED, 32'h5);
      tick(4);
      chk(32'(selected_channel_o), 32'h3, "non-revertive keeps");
      bus(1'b1, OFS_MODE, 32'h01);
      tick(4);
      chk(32'(selected_channel_o), 32'h5, "forced after revertive");
      for (int c = 1; c < 16; c++) begin
         bus(1'b1, OFS_FORCED, 32'(c));
         tick(4);
         chk(32'(selected_channel_o), 32'(c), "forced channel");
         bus(1'b0, OFS_FORCED, 32'h0);
         chk(rd, 32'(c), "forced readback");
      end
      bus(1'b1, OFS_FORCED, 32'h0);
      tick(4);
      chk(32'(selected_channel_o), 32'h3, "automatic choice");
   endtask

   task automatic holdover_irq;
      bus(1'b1, OFS_IRQ_CLR, 32'h7);
      chan_valid_i <= 15'h0;
      tick(6);
      chk(32'(dpll_state_o), 32'(ST_HOLDOVER), "holdover unforced");
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(32'(rd[IRQ_HOLDOVER]), 32'h1, "holdover event");
      chk(32'(irq_o), 32'h0, "masked irq");
      bus(1'b1, OFS_IRQ_EN, 32'h2);
      tick(2);
      chk(32'(irq_o), 32'h1, "enabled irq");
      bus(1'b1, OFS_IRQ_CLR, 32'h2);
      tick(2);
      chk(32'(irq_o), 32'h0, "cleared irq");
      bus(1'b1, OFS_FORCED, 32'h5);
      tick(6);
      chk(32'(selected_channel_o), 32'h5, "forced on failed input");
      chk(32'(dpll_state_o), 32'(ST_LOCKED), "forced locks");
      chan_valid_i <= 15'h7FFF;
      bus(1'b1, OFS_FORCED, 32'h0);
      tick(4);
   endtask

   task automatic sync_case(input logic [7:0] m, input logic [3:0] s, input logic e);
      sync_source_i <= s;
      bus(1'b1, OFS_MODE, {24'h0, m});
      tick(4);
      chk(32'(extsync_enable_o), 32'(e), "frame sync enable");
   endtask

   task automatic phase_timeout;
      bus(1'b1, OFS_MODE, 32'h41);
      phase_alarm_i <= 15'h0010;
      tick(1);
      phase_alarm_i <= 15'h0;
      tick(15);
      chk(32'(phase_alarm_o), 32'h10, "alarm before timeout");
      tick(10);
      chk(32'(phase_alarm_o), 32'h0, "alarm after timeout");
      bus(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(32'(rd[IRQ_PH_TIMEOUT]), 32'h1, "timeout event");
      bus(1'b1, OFS_MODE, 32'h01);
      phase_alarm_i <= 15'h0010;
      tick(1);
      phase_alarm_i <= 15'h0;
      tick(30);
      chk(32'(phase_alarm_o), 32'h10, "alarm kept");
      bus(1'b1, OFS_PHALARM, 32'h10);
      tick(2);
      chk(32'(phase_alarm_o), 32'h0, "alarm cleared by write");
   endtask

   // ==============================================
   // Main sequence
   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      chan_valid_i = 15'h7FFF;
      chan_prio_i = {15{4'h8}};
      chan_prio_i[11:8] = 4'h2;
      dpll_locked_i = 1'b1;
      sync_source_i = 4'h0;
      phase_alarm_i = 15'h0;
      network_type_pin_i = 1'b1;
      aux_output_source_i = 1'b0;
      aux_main_rate_i = 1'b0;
      tick(4);
      rst_i <= 1'b0;
      reset_values();
      mode_bits();
      forced_codes();
      holdover_irq();
      sync_case(8'h89, 4'h3, 1'b1);
      sync_case(8'h81, 4'h3, 1'b0);
      sync_case(8'h09, 4'h3, 1'b0);
      sync_case(8'h89, 4'h4, 1'b0);
      phase_timeout();
      give_verdict();
   end
endmodule // rsc_top_tb
`default_nettype wire
